// ### common/ell_pkg.sv
// Constants shared by the enable-latch bank and its register slave.
// Assumes a 4-bit AXI4-Lite byte address and 32-bit data.
package ell_pkg;
    // ========================================================
    // Register map
    localparam logic [3:0]  ADDR_STATE      = 4'h0;
    localparam logic [3:0]  ADDR_IRQ_STATUS = 4'h4;
    localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h8;
    localparam int          REG_COUNT       = 3;
    localparam int          SEL_STATE       = 0;
    localparam int          SEL_IRQ_STATUS  = 1;
    localparam int          SEL_IRQ_MASK    = 2;

    // ========================================================
    // State register fields
    localparam int          ST_SELFTEST_LSB = 0;
    localparam int          ST_RX_POWER     = 2;
    localparam int          ST_OUT_EN_LSB   = 3;
    localparam int          ST_LINK_FAULT_N = 5;
    localparam int          ST_FAULTS_LSB   = 6;

    // ========================================================
    // Interrupt bits
    localparam int          IRQ_COUNT       = 4;
    localparam int          IRQ_FAULT       = 0;
    localparam int          IRQ_SELFTEST    = 1;
    localparam int          IRQ_RX_POWER    = 2;
    localparam int          IRQ_OUT_EN      = 3;
    localparam logic [3:0]  IRQ_MASK_RST    = 4'h0;

    // ========================================================
    // Latch reset values
    localparam logic [1:0]  SELFTEST_RST    = 2'h3;
    localparam logic [0:0]  RX_POWER_RST    = 1'h1;
    localparam logic [1:0]  OUT_EN_RST      = 2'h0;

    // ========================================================
    // Bus responses and slave states
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [0:0] {
        WR_COLLECT = 1'b0,
        WR_RESP    = 1'b1
    } ell_wr_state_type;
endpackage

// ### logic/ell_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes the owner answers wr_ok, rd_data and rd_ok in the pulse cycle.
`timescale 1ns/1ps
module ell_axil_slave (
    input  wire logic        clk_i,     // Clock
    input  wire logic        rst_n_i,   // Async reset, low
    input  wire logic [3:0]  awaddr_i,  // Write address
    input  wire logic        awvalid_i, // Write address valid
    output logic             awready_o, // Write address ready
    input  wire logic [31:0] wdata_i,   // Write data
    input  wire logic [3:0]  wstrb_i,   // Write strobes
    input  wire logic        wvalid_i,  // Write data valid
    output logic             wready_o,  // Write data ready
    output logic [1:0]       bresp_o,   // Write response
    output logic             bvalid_o,  // Write response valid
    input  wire logic        bready_i,  // Write response ready
    input  wire logic [3:0]  araddr_i,  // Read address
    input  wire logic        arvalid_i, // Read address valid
    output logic             arready_o, // Read address ready
    output logic [31:0]      rdata_o,   // Read data
    output logic [1:0]       rresp_o,   // Read response
    output logic             rvalid_o,  // Read data valid
    input  wire logic        rready_i,  // Read data ready
    output logic             wr_pulse_o, // Register write strobe
    output logic [3:0]       wr_addr_o, // Write address held
    output logic [31:0]      wr_data_o, // Write data held
    output logic [3:0]       wr_strb_o, // Write strobes held
    input  wire logic        wr_ok_i,   // Write address mapped
    output logic             rd_pulse_o, // Register read strobe
    output logic [3:0]       rd_addr_o, // Read address held
    input  wire logic [31:0] rd_data_i, // Read data from owner
    input  wire logic        rd_ok_i    // Read address mapped
);
    ell_pkg::ell_wr_state_type wr_state;
    logic aw_got;
    logic w_got;
    logic ar_got;
    logic next_aw_got;
    logic next_w_got;
    logic next_ar_got;
    logic wr_done;

    assign wr_done     = bvalid_o && bready_i;
    assign next_aw_got = (aw_got && !wr_done) || (awvalid_i && awready_o);
    assign next_w_got  = (w_got && !wr_done) || (wvalid_i && wready_o);
    assign next_ar_got = (ar_got && !(rvalid_o && rready_i)) || (arvalid_i && arready_o);
    assign wr_pulse_o  = aw_got && w_got && (wr_state == ell_pkg::WR_COLLECT);
    assign rd_pulse_o  = ar_got && !rvalid_o;

    // ========================================================
    // Write address and data, taken in either order
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_got    <= 1'b0;
            w_got     <= 1'b0;
            awready_o <= 1'b0;
            wready_o  <= 1'b0;
            wr_addr_o <= 4'h0;
            wr_data_o <= 32'h0;
            wr_strb_o <= 4'h0;
        end else begin
            aw_got    <= next_aw_got;
            w_got     <= next_w_got;
            awready_o <= !next_aw_got;
            wready_o  <= !next_w_got;
            if (awvalid_i && awready_o) begin
                wr_addr_o <= awaddr_i;
            end
            if (wvalid_i && wready_o) begin
                wr_data_o <= wdata_i;
                wr_strb_o <= wstrb_i;
            end
        end
    end

    // ========================================================
    // Write response
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_state <= ell_pkg::WR_COLLECT;
            bvalid_o <= 1'b0;
            bresp_o  <= ell_pkg::RESP_OKAY;
        end else begin
            case (wr_state)
                ell_pkg::WR_COLLECT: begin
                    if (wr_pulse_o) begin
                        bvalid_o <= 1'b1;
                        bresp_o  <= wr_ok_i ? ell_pkg::RESP_OKAY : ell_pkg::RESP_SLVERR;
                        wr_state <= ell_pkg::WR_RESP;
                    end
                end
                ell_pkg::WR_RESP: begin
                    if (bready_i) begin
                        bvalid_o <= 1'b0;
                        wr_state <= ell_pkg::WR_COLLECT;
                    end
                end
                default: begin
                    bvalid_o <= 1'b0;
                    wr_state <= ell_pkg::WR_COLLECT;
                end
            endcase
        end
    end

    // ========================================================
    // Read channel
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ar_got    <= 1'b0;
            arready_o <= 1'b0;
            rd_addr_o <= 4'h0;
            rvalid_o  <= 1'b0;
            rdata_o   <= 32'h0;
            rresp_o   <= ell_pkg::RESP_OKAY;
        end else begin
            ar_got    <= next_ar_got;
            arready_o <= !next_ar_got;
            if (arvalid_i && arready_o) begin
                rd_addr_o <= araddr_i;
            end
            if (rd_pulse_o) begin
                rvalid_o <= 1'b1;
                rdata_o  <= rd_data_i;
                rresp_o  <= rd_ok_i ? ell_pkg::RESP_OKAY : ell_pkg::RESP_SLVERR;
            end else if (rvalid_o && rready_i) begin
                rvalid_o <= 1'b0;
            end
        end
    end
endmodule

// ### logic/ell_enable_latch.sv
// One clocked enable latch fed from the shared enable bus.
// Assumes latch enable, bus and sampled device reset are synchronous.
`timescale 1ns/1ps
module ell_enable_latch #(
    parameter int               WIDTH      = 2,
    parameter logic [WIDTH-1:0] RESET_VAL  = '0,
    parameter bit               CLEAR_OPEN = 1'b0
) (
    input  wire logic             clk_i,       // Clock
    input  wire logic             rst_n_i,     // Async reset, low
    input  wire logic             dev_rst_n_i, // Sampled device reset, low
    input  wire logic             le_i,        // Latch enable
    input  wire logic [WIDTH-1:0] d_i,         // Bus bits
    output logic      [WIDTH-1:0] q_o,         // Held value
    output logic                  cap_o        // Pulse on capture
);
    logic le_d;

    // ========================================================
    // Latch body
    // Open latch follows one clock later; reset clears only when closed
    // unless CLEAR_OPEN is set.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_o <= RESET_VAL;
        end else if (!dev_rst_n_i && (!le_i || CLEAR_OPEN)) begin
            q_o <= RESET_VAL;
        end else if (le_i) begin
            q_o <= d_i;
        end
    end

    // ========================================================
    // Capture event on falling enable
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            le_d  <= 1'b0;
            cap_o <= 1'b0;
        end else begin
            le_d  <= le_i;
            cap_o <= le_d && !le_i;
        end
    end
endmodule

// ### logic/ell_top.sv
// Enable-latch bank and link fault indication of a serial transceiver.
// Assumes all pin inputs are synchronous to CLOCK_I.
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module ell_top (
    input  wire logic        CLOCK_I,                // 125 MHz clock
    input  wire logic        RST_N_I,                // Async reset, low
    input  wire logic        DEVICE_RESET_N_I,       // Device reset pin, low
    input  wire logic        SELFTEST_LATCH_EN_I,    // Self-test latch enable
    input  wire logic        RX_POWER_LATCH_EN_I,    // Receive power latch enable
    input  wire logic        OUT_ENABLE_LATCH_EN_I,  // Output-enable latch enable
    input  wire logic [1:0]  SHARED_ENABLE_BUS_I,    // Shared enable bus
    input  wire logic        FREQ_FAULT_I,           // Frequency out of range
    input  wire logic        AMPLITUDE_LOW_I,        // Amplitude too low
    input  wire logic        DENSITY_LOW_I,          // Transition density too low
    output logic             TX_SELFTEST_N_O,        // Low: transmit self-test
    output logic             RX_SELFTEST_N_O,        // Low: receive self-test
    output logic             RX_POWER_SAVE_O,        // High: receive powered down
    output logic [1:0]       OUT_DRIVER_EN_O,        // Serial driver enables
    output logic             LINK_FAULT_N_O,         // Link fault, low
    output logic             IRQ_O,                  // Interrupt, high
    input  wire logic [3:0]  S_AXI_AWADDR_I,         // Write address
    input  wire logic        S_AXI_AWVALID_I,        // Write address valid
    output logic             S_AXI_AWREADY_O,        // Write address ready
    input  wire logic [31:0] S_AXI_WDATA_I,          // Write data
    input  wire logic [3:0]  S_AXI_WSTRB_I,          // Write strobes
    input  wire logic        S_AXI_WVALID_I,         // Write data valid
    output logic             S_AXI_WREADY_O,         // Write data ready
    output logic [1:0]       S_AXI_BRESP_O,          // Write response
    output logic             S_AXI_BVALID_O,         // Write response valid
    input  wire logic        S_AXI_BREADY_I,         // Write response ready
    input  wire logic [3:0]  S_AXI_ARADDR_I,         // Read address
    input  wire logic        S_AXI_ARVALID_I,        // Read address valid
    output logic             S_AXI_ARREADY_O,        // Read address ready
    output logic [31:0]      S_AXI_RDATA_O,          // Read data
    output logic [1:0]       S_AXI_RRESP_O,          // Read response
    output logic             S_AXI_RVALID_O,         // Read data valid
    input  wire logic        S_AXI_RREADY_I          // Read data ready
);
    logic [1:0]  selftest_q;
    logic [0:0]  rx_power_q;
    logic [1:0]  out_en_q;
    logic        selftest_cap;
    logic        rx_power_cap;
    logic        out_en_cap;
    logic        fault_any;
    logic [3:0]  irq_status;
    logic [3:0]  irq_mask;
    logic [3:0]  irq_event;
    logic [3:0]  irq_clear;
    logic [3:0]  next_irq_status;
    logic        wr_pulse;
    logic [3:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        rd_pulse;
    logic [3:0]  rd_addr;
    logic [31:0] rd_data;
    logic [2:0]  wr_sel;
    logic [2:0]  rd_sel;

    // ========================================================
    // Address decode, one-hot; zero when unmapped
    function automatic logic [2:0] decode_reg(input logic [3:0] addr);
        logic [2:0] sel;
        sel = 3'h0;
        case (addr)
            ell_pkg::ADDR_STATE:      sel[ell_pkg::SEL_STATE]      = 1'b1;
            ell_pkg::ADDR_IRQ_STATUS: sel[ell_pkg::SEL_IRQ_STATUS] = 1'b1;
            ell_pkg::ADDR_IRQ_MASK:   sel[ell_pkg::SEL_IRQ_MASK]   = 1'b1;
            default:                  sel = 3'h0;
        endcase
        return sel;
    endfunction

    // ========================================================
    // Enable latches
    // Self-test: bit 0 transmit, bit 1 receive; one means normal traffic.
    ell_enable_latch #(
        .WIDTH      (2),
        .RESET_VAL  (ell_pkg::SELFTEST_RST),
        .CLEAR_OPEN (1'b0)
    ) u_selftest (
        .clk_i       (CLOCK_I),
        .rst_n_i     (RST_N_I),
        .dev_rst_n_i (DEVICE_RESET_N_I),
        .le_i        (SELFTEST_LATCH_EN_I),
        .d_i         (SHARED_ENABLE_BUS_I),
        .q_o         (selftest_q),
        .cap_o       (selftest_cap)
    );

    // Receive power: one means PLL and analog front end powered down.
    ell_enable_latch #(
        .WIDTH      (1),
        .RESET_VAL  (ell_pkg::RX_POWER_RST),
        .CLEAR_OPEN (1'b0)
    ) u_rx_power (
        .clk_i       (CLOCK_I),
        .rst_n_i     (RST_N_I),
        .dev_rst_n_i (DEVICE_RESET_N_I),
        .le_i        (RX_POWER_LATCH_EN_I),
        .d_i         (SHARED_ENABLE_BUS_I[0:0]),
        .q_o         (rx_power_q),
        .cap_o       (rx_power_cap)
    );

    // Output enables clear on any sampled reset, open or closed.
    ell_enable_latch #(
        .WIDTH      (2),
        .RESET_VAL  (ell_pkg::OUT_EN_RST),
        .CLEAR_OPEN (1'b1)
    ) u_out_en (
        .clk_i       (CLOCK_I),
        .rst_n_i     (RST_N_I),
        .dev_rst_n_i (DEVICE_RESET_N_I),
        .le_i        (OUT_ENABLE_LATCH_EN_I),
        .d_i         (SHARED_ENABLE_BUS_I),
        .q_o         (out_en_q),
        .cap_o       (out_en_cap)
    );

    assign TX_SELFTEST_N_O = selftest_q[0];
    assign RX_SELFTEST_N_O = selftest_q[1];
    assign RX_POWER_SAVE_O = rx_power_q[0];
    assign OUT_DRIVER_EN_O = out_en_q;

    // ========================================================
    // Link fault
    // Powered-down receiver counts as a fault in its own right.
    assign fault_any = FREQ_FAULT_I || AMPLITUDE_LOW_I || DENSITY_LOW_I || rx_power_q[0];

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            LINK_FAULT_N_O <= 1'b1;
        end else begin
            LINK_FAULT_N_O <= !fault_any;
        end
    end

    // ========================================================
    // Interrupts: sticky, write one to clear, set wins
    assign irq_event[ell_pkg::IRQ_FAULT]    = fault_any && LINK_FAULT_N_O;
    assign irq_event[ell_pkg::IRQ_SELFTEST] = selftest_cap;
    assign irq_event[ell_pkg::IRQ_RX_POWER] = rx_power_cap;
    assign irq_event[ell_pkg::IRQ_OUT_EN]   = out_en_cap;

    assign wr_sel    = decode_reg(wr_addr);
    assign rd_sel    = decode_reg(rd_addr);
    assign irq_clear = (wr_pulse && wr_sel[ell_pkg::SEL_IRQ_STATUS] && wr_strb[0])
                     ? wr_data[3:0] : 4'h0;
    assign next_irq_status = (irq_status & ~irq_clear) | irq_event;

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_status <= 4'h0;
            IRQ_O      <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            IRQ_O      <= |(next_irq_status & irq_mask);
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_mask <= ell_pkg::IRQ_MASK_RST;
        end else if (wr_pulse && wr_sel[ell_pkg::SEL_IRQ_MASK] && wr_strb[0]) begin
            irq_mask <= wr_data[3:0];
        end
    end

    // ========================================================
    // Register read mux
    always_comb begin
        rd_data = 32'h0;
        if (rd_sel[ell_pkg::SEL_STATE]) begin
            rd_data[ell_pkg::ST_SELFTEST_LSB +: 2] = selftest_q;
            rd_data[ell_pkg::ST_RX_POWER]          = rx_power_q[0];
            rd_data[ell_pkg::ST_OUT_EN_LSB +: 2]   = out_en_q;
            rd_data[ell_pkg::ST_LINK_FAULT_N]      = LINK_FAULT_N_O;
            rd_data[ell_pkg::ST_FAULTS_LSB +: 3]   = {DENSITY_LOW_I, AMPLITUDE_LOW_I,
                                                      FREQ_FAULT_I};
        end else if (rd_sel[ell_pkg::SEL_IRQ_STATUS]) begin
            rd_data[3:0] = irq_status;
        end else if (rd_sel[ell_pkg::SEL_IRQ_MASK]) begin
            rd_data[3:0] = irq_mask;
        end
    end

    ell_axil_slave u_slave (
        .clk_i      (CLOCK_I),
        .rst_n_i    (RST_N_I),
        .awaddr_i   (S_AXI_AWADDR_I),
        .awvalid_i  (S_AXI_AWVALID_I),
        .awready_o  (S_AXI_AWREADY_O),
        .wdata_i    (S_AXI_WDATA_I),
        .wstrb_i    (S_AXI_WSTRB_I),
        .wvalid_i   (S_AXI_WVALID_I),
        .wready_o   (S_AXI_WREADY_O),
        .bresp_o    (S_AXI_BRESP_O),
        .bvalid_o   (S_AXI_BVALID_O),
        .bready_i   (S_AXI_BREADY_I),
        .araddr_i   (S_AXI_ARADDR_I),
        .arvalid_i  (S_AXI_ARVALID_I),
        .arready_o  (S_AXI_ARREADY_O),
        .rdata_o    (S_AXI_RDATA_O),
        .rresp_o    (S_AXI_RRESP_O),
        .rvalid_o   (S_AXI_RVALID_O),
        .rready_i   (S_AXI_RREADY_I),
        .wr_pulse_o (wr_pulse),
        .wr_addr_o  (wr_addr),
        .wr_data_o  (wr_data),
        .wr_strb_o  (wr_strb),
        .wr_ok_i    (|wr_sel),
        .rd_pulse_o (rd_pulse),
        .rd_addr_o  (rd_addr),
        .rd_data_i  (rd_data),
        .rd_ok_i    (|rd_sel)
    );

    // ========================================================
    // Assertions
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);

    selftest_follow_a: assert property (
        SELFTEST_LATCH_EN_I && DEVICE_RESET_N_I
        |=> {RX_SELFTEST_N_O, TX_SELFTEST_N_O} == $past(SHARED_ENABLE_BUS_I))
        else $error("self-test latch not following bus");

    selftest_hold_a: assert property (
        $fell(SELFTEST_LATCH_EN_I) && DEVICE_RESET_N_I ##1
        (!SELFTEST_LATCH_EN_I && DEVICE_RESET_N_I) [*2]
        |-> $stable({RX_SELFTEST_N_O, TX_SELFTEST_N_O}))
        else $error("self-test latch not holding");

    selftest_reset_a: assert property (
        !DEVICE_RESET_N_I && !SELFTEST_LATCH_EN_I
        |=> TX_SELFTEST_N_O && RX_SELFTEST_N_O)
        else $error("self-test latch not cleared by reset");

    rx_follow_a: assert property (
        RX_POWER_LATCH_EN_I && DEVICE_RESET_N_I
        |=> RX_POWER_SAVE_O == $past(SHARED_ENABLE_BUS_I[0]))
        else $error("receive power latch not following bus");

    rx_hold_a: assert property (
        !RX_POWER_LATCH_EN_I && DEVICE_RESET_N_I |=> $stable(RX_POWER_SAVE_O))
        else $error("receive power latch changed while closed");

    rx_reset_a: assert property (
        !DEVICE_RESET_N_I && !RX_POWER_LATCH_EN_I |=> RX_POWER_SAVE_O)
        else $error("receive power latch not cleared by reset");

    oe_follow_a: assert property (
        OUT_ENABLE_LATCH_EN_I && DEVICE_RESET_N_I
        |=> OUT_DRIVER_EN_O == $past(SHARED_ENABLE_BUS_I))
        else $error("output-enable latch not following bus");

    oe_reset_a: assert property (
        !DEVICE_RESET_N_I |=> OUT_DRIVER_EN_O == ell_pkg::OUT_EN_RST)
        else $error("output enables not cleared by reset");

    fault_out_a: assert property (
        FREQ_FAULT_I || AMPLITUDE_LOW_I || DENSITY_LOW_I || RX_POWER_SAVE_O
        |=> !LINK_FAULT_N_O)
        else $error("link fault not flagged");

    fault_clear_a: assert property (
        !(FREQ_FAULT_I || AMPLITUDE_LOW_I || DENSITY_LOW_I || RX_POWER_SAVE_O)
        |=> LINK_FAULT_N_O)
        else $error("link fault flagged without cause");

    reset_all_a: assert property (
        !DEVICE_RESET_N_I && !SELFTEST_LATCH_EN_I && !RX_POWER_LATCH_EN_I
        |=> TX_SELFTEST_N_O && RX_SELFTEST_N_O && RX_POWER_SAVE_O && !(|OUT_DRIVER_EN_O))
        else $error("latches not all cleared by reset");

    // ========================================================
    // Interrupt, register bus, output-enable hold and covers
    irq_set_a: assert property (
        irq_event[ell_pkg::IRQ_SELFTEST]
        |=> irq_status[ell_pkg::IRQ_SELFTEST])
        else $error("status set lost");

    irq_clear_a: assert property (
        irq_clear[ell_pkg::IRQ_OUT_EN] && !irq_event[ell_pkg::IRQ_OUT_EN]
        |=> !irq_status[ell_pkg::IRQ_OUT_EN])
        else $error("status bit not cleared");

    irq_level_a: assert property (
        $stable(irq_mask)
        |-> IRQ_O == |(irq_status & irq_mask))
        else $error("interrupt level wrong");

    fault_irq_a: assert property (
        $fell(LINK_FAULT_N_O)
        |-> irq_status[ell_pkg::IRQ_FAULT])
        else $error("fault onset not recorded");

    rx_cap_a: assert property (
        $fell(RX_POWER_LATCH_EN_I) ##1 1'b1
        |=> irq_status[ell_pkg::IRQ_RX_POWER])
        else $error("receive power capture not flagged");

    oe_hold_a: assert property (
        !OUT_ENABLE_LATCH_EN_I && DEVICE_RESET_N_I
        |=> $stable(OUT_DRIVER_EN_O))
        else $error("output enables changed while closed");

    aw_refuse_a: assert property (
        S_AXI_BVALID_O
        |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
        else $error("write taken while response pending");

    rd_answer_a: assert property (
        rd_pulse
        |=> S_AXI_RVALID_O && S_AXI_RDATA_O == $past(rd_data))
        else $error("read answer wrong");

    irq_sticky_a: assert property (
        irq_status[ell_pkg::IRQ_SELFTEST] && irq_clear[ell_pkg::IRQ_SELFTEST] == 1'b0
        |=> irq_status[ell_pkg::IRQ_SELFTEST])
        else $error("sticky status bit lost");

    selftest_cap_c: cover property (
        SELFTEST_LATCH_EN_I ##1 !SELFTEST_LATCH_EN_I ##2 irq_status[ell_pkg::IRQ_SELFTEST]);
    rx_on_c: cover property ($fell(RX_POWER_SAVE_O));
    fault_c: cover property ($fell(LINK_FAULT_N_O) ##1 IRQ_O);
    wr_rd_c: cover property (S_AXI_BVALID_O && S_AXI_RVALID_O);
    oe_cap_c: cover property ($fell(OUT_ENABLE_LATCH_EN_I) ##2 irq_status[ell_pkg::IRQ_OUT_EN]);
endmodule

// ### verification/ell_host_model.sv
// Host model: loads one latch by pulsing its enable over a held bus.
// Assumes go_i is a one-cycle request driven after a clock edge.
`timescale 1ns/1ps
module ell_host_model (
    input  wire logic       clk_i,       // Clock
    input  wire logic       go_i,        // Start one latch load
    input  wire logic [1:0] sel_i,       // Latch index
    input  wire logic [1:0] val_i,       // Bus value to load
    output logic [2:0]      le_o = 3'h0, // Latch enables
    output logic [1:0]      bus_o = 2'h3 // Shared enable bus
);
    logic [1:0] step = 2'h0;
    always @(posedge clk_i) begin
        if (go_i) begin
            bus_o <= val_i;
            le_o <= 3'h1 << sel_i;
            step <= 2'h1;
        end else if (step == 2'h1) begin
            le_o <= 3'h0;
            step <= 2'h2;
        end else if (step == 2'h2) begin
            // Released bus floats to the pull-up level
            bus_o <= 2'h3;
            step <= 2'h0;
        end
    end
endmodule

// ### verification/tb_top.sv
// Bench: host model on the latch pins, AXI4-Lite master tasks.
// Assumes the register map of ell_pkg.
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'h0, rst_n = 1'h0, drn = 1'h1, go = 1'h0, awv = 1'h0, wv = 1'h0;
    logic        bry = 1'h0, arv = 1'h0, rry = 1'h0, awr, wr, bv, arr, rv;
    logic        txn, rxn, sav, lfn, irq;
    logic [1:0]  sel = 2'h0, val = 2'h0, bus, br, rr, drv, rsp;
    logic [2:0]  le, flt = 3'h0;
    logic [3:0]  aw = 4'h0, ar = 4'h0, stb = 4'hF;
    logic [31:0] wd = 32'h0, rd, rdv;
    int          fails = 0, check_count = 0, n;
    always #4 clk = ~clk;
    ell_host_model HOST (.clk_i(clk), .go_i(go), .sel_i(sel), .val_i(val), .le_o(le), .bus_o(bus));
    ell_top DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .DEVICE_RESET_N_I(drn),
        .SELFTEST_LATCH_EN_I(le[0]), .RX_POWER_LATCH_EN_I(le[1]), .OUT_ENABLE_LATCH_EN_I(le[2]),
        .SHARED_ENABLE_BUS_I(bus), .FREQ_FAULT_I(flt[0]), .AMPLITUDE_LOW_I(flt[1]),
        .DENSITY_LOW_I(flt[2]), .TX_SELFTEST_N_O(txn), .RX_SELFTEST_N_O(rxn),
        .RX_POWER_SAVE_O(sav), .OUT_DRIVER_EN_O(drv), .LINK_FAULT_N_O(lfn), .IRQ_O(irq),
        .S_AXI_AWADDR_I(aw), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
        .S_AXI_WSTRB_I(stb), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(br),
        .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry), .S_AXI_ARADDR_I(ar), .S_AXI_ARVALID_I(arv),
        .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
        .S_AXI_RREADY_I(rry));
    // ========================================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s exp %0h got %0h", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("fails %0d checks %0d", fails, check_count);
        if (fails == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic tmo;
        chk("wait_limit", 32'h0, 32'h1);
        close_out;
    endtask
    task automatic ld(input logic [1:0] s, v);
        sel <= s; val <= v; go <= 1'h1;
        @(posedge clk) go <= 1'h0;
        repeat (5) @(posedge clk);
    endtask
    task automatic dres;
        drn <= 1'h0;
        @(posedge clk) drn <= 1'h1;
        repeat (3) @(posedge clk);
    endtask
    task automatic wrt(input logic [3:0] a, input logic [31:0] d);
        aw <= a; wd <= d; awv <= 1'h1; wv <= 1'h1; bry <= 1'h1;
        for (n = 0; n < 30; n++) begin
            @(posedge clk);
            if (awr) awv <= 1'h0;
            if (wr) wv <= 1'h0;
            if (bv) break;
        end
        rsp = br;
        bry <= 1'h0;
        if (n == 30) tmo;
        repeat (2) @(posedge clk);
    endtask
    task automatic rdt(input logic [3:0] a);
        ar <= a; arv <= 1'h1; rry <= 1'h1;
        for (n = 0; n < 30; n++) begin
            @(posedge clk);
            if (arr) arv <= 1'h0;
            if (rv) break;
        end
        rdv = rd; rsp = rr; rry <= 1'h0;
        if (n == 30) tmo;
        @(posedge clk);
    endtask
    // ========================================
    // Scenarios
    task automatic t_pins;
        chk("rst_pins", 6'h38, {txn, rxn, sav, drv, lfn});
        ld(2'h0, 2'h2); chk("st", 2'h2, {rxn, txn});
        dres; chk("st_rst", 2'h3, {rxn, txn});
        ld(2'h1, 2'h2); chk("sav", 1'h0, sav);
        chk("lfn", 1'h1, lfn);
        for (int i = 0; i < 3; i++) begin
            flt <= 3'h1 << i; repeat (3) @(posedge clk);
            chk("lfn_f", 1'h0, lfn);
            flt <= 3'h0; repeat (3) @(posedge clk);
        end
        ld(2'h1, 2'h1); chk("sav1", 1'h1, sav);
        ld(2'h1, 2'h0); dres; chk("sav_rst", 1'h1, sav);
        ld(2'h2, 2'h1); chk("drv", 2'h1, drv);
        dres; chk("drv_rst", 2'h0, drv);
    endtask
    task automatic t_regs;
        wrt(4'h4, 32'hF); wrt(4'h8, 32'h0);
        ld(2'h0, 2'h1); chk("irq_masked", 1'h0, irq);
        wrt(4'h8, 32'hF); chk("irq", 1'h1, irq); chk("bresp", 2'h0, rsp);
        rdt(4'h4); chk("sts", 1'h1, rdv[1]); chk("rresp", 2'h0, rsp);
        rdt(4'h0); chk("state", 2'h1, rdv[1:0]);
        wrt(4'h4, 32'hF); chk("irq_clr", 1'h0, irq);
        rdt(4'hC); chk("slverr", 2'h2, rsp);
        wrt(4'hC, 32'h1); chk("wr_slverr", 2'h2, rsp);
        stb <= 4'h0; wrt(4'h8, 32'h0); stb <= 4'hF;
        rdt(4'h8); chk("strb0", 4'hF, rdv[3:0]);
        ld(2'h1, 2'h0); ld(2'h2, 2'h0); flt <= 3'h4; repeat (3) @(posedge clk);
        rdt(4'h4); chk("sts_ev", 4'hD, rdv[3:0]);
        rdt(4'h0); chk("state_f", 32'h101, rdv);
        flt <= 3'h0;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge clk);
        t_pins;
        t_regs;
        close_out;
    end
endmodule
